/* plc_pkg.sv */
package plc_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_SYS_KHZ = 125000;
   localparam real LPS_RESET_MIN_US = 1.2;
   localparam real LPS_DISABLE_MIN_US = 25.0;
   localparam int unsigned LPS_RESET_CYC = int'($ceil(LPS_RESET_MIN_US * CLK_SYS_KHZ / 1000.0));
   localparam int unsigned LPS_DISABLE_CYC =
      int'($ceil(LPS_DISABLE_MIN_US * CLK_SYS_KHZ / 1000.0));
   localparam int unsigned LPS_CNT_W = 12;

   // ------------------------------------------------------------
   // Link-on square wave: toggle rate is twice the output frequency
   // ------------------------------------------------------------
   localparam int unsigned LINK_ON_KHZ = 6144;
   localparam int unsigned LINK_ON_STEP = 2 * LINK_ON_KHZ;
   localparam int unsigned ACC_W = 17;

   // ------------------------------------------------------------
   // Interface clock divider
   // ------------------------------------------------------------
   localparam int unsigned SCLK_STEP = 1;
   localparam int unsigned SCLK_MOD = 2;

   // ------------------------------------------------------------
   // Start-up sequence after re-enable, counted in interface clocks
   // ------------------------------------------------------------
   localparam logic [3:0] STARTUP_ZERO_LAST = 4'h7;
   localparam logic [3:0] STARTUP_AC_ZERO = 4'h1;
   localparam logic [3:0] STARTUP_PREFIX = 4'h8;

   // ------------------------------------------------------------
   // Control and data line codes driven by the device
   // ------------------------------------------------------------
   localparam logic [1:0] CTL_IDLE = 2'h0;
   localparam logic [1:0] CTL_STATUS = 2'h1;
   localparam logic [1:0] CTL_RECEIVE = 2'h2;
   localparam logic [1:0] CTL_GRANT = 2'h3;
   localparam logic [7:0] DATA_PREFIX = 8'h00_ff;
   localparam logic [7:0] DATA_ZERO = 8'h00_00;

   typedef enum logic [1:0] {
      PLC_ACTIVE = 2'b00,
      PLC_RESET = 2'b01,
      PLC_DISABLED = 2'b10,
      PLC_STARTUP = 2'b11
   } plc_state_e;

endpackage

/* plc_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module plc_pin_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pin and clean level
   input wire logic pin_in,
   output logic level_out
);
   logic s1_reg, s2_reg, s3_reg, lvl_reg;
   logic lvl_next;

   // ------------------------------------------------------------
   // A change counts only once the last two stages agree.
   // ------------------------------------------------------------
   always_comb begin
      lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         lvl_reg <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   assign level_out = lvl_reg;
endmodule
`default_nettype wire

/* plc_wave_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module plc_wave_gen #(
   parameter int unsigned STEP = 1,
   parameter int unsigned MODULUS = 2,
   parameter int unsigned ACC_W = 17
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control
   input wire logic run,
   // Wave
   output logic wave,
   output logic rise
);
   logic [ACC_W-1:0] acc_reg, acc_next;
   logic wave_reg, wave_next;
   logic [ACC_W:0] sum;

   // ------------------------------------------------------------
   // Fractional accumulator: edges land within one clock of ideal,
   // which trades a little jitter for an exact average frequency.
   // ------------------------------------------------------------
   always_comb begin
      sum = {1'b0, acc_reg} + (ACC_W+1)'(STEP);
      acc_next = acc_reg;
      wave_next = wave_reg;
      rise = 1'b0;
      if (!run) begin
         acc_next = '0;
         wave_next = 1'b0;
      end else if (sum >= (ACC_W+1)'(MODULUS)) begin
         acc_next = ACC_W'(sum - (ACC_W+1)'(MODULUS));
         wave_next = !wave_reg;
         rise = !wave_reg;
      end else begin
         acc_next = sum[ACC_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_reg <= '0;
         wave_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         wave_reg <= wave_next;
      end
   end

   assign wave = wave_reg;
endmodule
`default_nettype wire

/* plc_link_ctl.sv */
//
// Behaviour
// RULE1: Low LPS for reset time resets interface.
// RULE2: Low LPS for disable time disables interface.
// RULE3: Interface reset cancels pending bus/read requests.
// RULE4: Reset during link transmit ends that transfer.
// RULE5: No status while disabled, none replayed later.
// RULE6: LPS return restarts the interface clock.
// RULE7: DC start: seven zero clocks, then prefix.
// RULE8: AC start: one zero clock, prefix, else float.
// RULE9: Ongoing reception keeps prefix until it ends.
// RULE10: Link keeps LPS pulse phases 0.09-1.00 us.
// RULE11: Link-on driven low whenever deasserted.
// RULE12: Link-on asserted on event when LPS low.
// RULE13: Link-on holds; bus reset clears with exceptions.
// RULE14: Link-on toggles at 6.144 MHz, 50 percent.
// RULE15: Control codes idle, status, receive, grant.
// RULE16: Link codes idle, hold, transmit; 11 reserved.
// RULE17: Reception takes priority over everything else.
// RULE18: Device owns control lines except requests.
// RULE19: Low-time counter restarts on every LPS edge.
//
`timescale 1ns/10ps
`default_nettype none
module plc_link_ctl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Link power state pin and coupling mode
   input wire logic lps_pin,
   input wire logic dc_coupling,
   // Bus side events and conditions
   input wire logic rx_active,
   input wire logic [7:0] rx_data,
   input wire logic status_req,
   input wire logic [7:0] status_data,
   input wire logic grant_req,
   input wire logic link_tx_active,
   input wire logic link_on_event,
   input wire logic bus_reset,
   input wire logic port_event_bit,
   input wire logic watchdog_bit,
   input wire logic fault_condition,
   input wire logic link_control_enable_bit,
   // Interface clock pin
   output logic sclk_o,
   output logic sclk_oe,
   // Control and data pins
   output logic [1:0] ctl_o,
   output logic ctl_oe,
   output logic [7:0] d_o,
   output logic d_oe,
   // Link-on pin
   output logic link_on_o,
   // Notifications to the core
   output logic req_cancel,
   output logic tx_forced_end,
   output logic status_drop,
   output plc_pkg::plc_state_e if_state
);
   import plc_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   logic lps_lvl;

   plc_pin_sync u_lps_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_in(lps_pin),
      .level_out(lps_lvl)
   );

   // ------------------------------------------------------------
   // LPS low-time measurement
   // ------------------------------------------------------------
   logic lps_prev_reg, lps_prev_next;
   logic [LPS_CNT_W-1:0] low_cnt_reg, low_cnt_next;
   logic lps_rise;
   logic low_reset_hit;
   logic low_disable_hit;

   // A pulsed LPS never lets the count reach the reset time, so the
   // pulse train is seen as asserted without any separate detector.
   always_comb begin
      lps_prev_next = lps_lvl;
      lps_rise = lps_lvl && !lps_prev_reg;
      low_cnt_next = low_cnt_reg;
      if (lps_lvl != lps_prev_reg) begin
         low_cnt_next = '0; // RULE19
      end else if (!lps_lvl && low_cnt_reg != LPS_CNT_W'(LPS_DISABLE_CYC)) begin
         low_cnt_next = low_cnt_reg + LPS_CNT_W'(1);
      end
      low_reset_hit = !lps_lvl && (low_cnt_reg >= LPS_CNT_W'(LPS_RESET_CYC)); // RULE1
      low_disable_hit = !lps_lvl && (low_cnt_reg >= LPS_CNT_W'(LPS_DISABLE_CYC)); // RULE2
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lps_prev_reg <= 1'b0;
         low_cnt_reg <= '0;
      end else begin
         lps_prev_reg <= lps_prev_next;
         low_cnt_reg <= low_cnt_next;
      end
   end

   // ------------------------------------------------------------
   // Interface clock and link-on wave
   // ------------------------------------------------------------
   logic sclk_run;
   logic sclk_wave;
   logic sclk_rise;
   logic lon_wave;
   logic lon_active_reg, lon_active_next;

   plc_wave_gen #(
      .STEP(SCLK_STEP),
      .MODULUS(SCLK_MOD),
      .ACC_W(ACC_W)
   ) u_sclk_gen (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(sclk_run),
      .wave(sclk_wave),
      .rise(sclk_rise)
   );

   plc_wave_gen #(
      .STEP(LINK_ON_STEP),
      .MODULUS(CLK_SYS_KHZ),
      .ACC_W(ACC_W)
   ) u_lon_gen (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(lon_active_reg),
      .wave(lon_wave),
      .rise()
   );

   // ------------------------------------------------------------
   // Interface power state
   // ------------------------------------------------------------
   plc_state_e state_reg, state_next;
   logic [3:0] start_cnt_reg, start_cnt_next;
   logic cancel_next, tx_end_next, drop_next;
   logic cancel_reg, tx_end_reg, drop_reg;

   always_comb begin
      state_next = state_reg;
      start_cnt_next = start_cnt_reg;
      cancel_next = 1'b0;
      tx_end_next = 1'b0;
      drop_next = drop_reg;
      case (state_reg)
         PLC_ACTIVE, PLC_STARTUP: begin
            if (low_reset_hit) begin
               state_next = PLC_RESET;
               cancel_next = 1'b1; // RULE3
               tx_end_next = link_tx_active; // RULE4
            end else if (state_reg == PLC_STARTUP && sclk_rise) begin
               start_cnt_next = start_cnt_reg + 4'h1;
               if (start_cnt_reg == STARTUP_PREFIX) begin
                  // A packet already arriving keeps the prefix up until it ends.
                  start_cnt_next = start_cnt_reg; // RULE9
                  state_next = rx_active ? PLC_STARTUP : PLC_ACTIVE;
               end
            end
         end
         PLC_RESET: begin
            if (low_disable_hit) begin
               state_next = PLC_DISABLED; // RULE2
               drop_next = 1'b1; // RULE5
            end else if (lps_rise) begin
               state_next = PLC_STARTUP;
               start_cnt_next = 4'h0;
            end
         end
         PLC_DISABLED: begin
            if (lps_rise) begin
               state_next = PLC_STARTUP; // RULE6
               start_cnt_next = 4'h0;
               drop_next = 1'b0;
            end
         end
         default: begin
            state_next = PLC_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= PLC_DISABLED;
         start_cnt_reg <= 4'h0;
         cancel_reg <= 1'b0;
         tx_end_reg <= 1'b0;
         drop_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         start_cnt_reg <= start_cnt_next;
         cancel_reg <= cancel_next;
         tx_end_reg <= tx_end_next;
         drop_reg <= drop_next;
      end
   end

   // The clock keeps running through an interface reset; only the
   // disabled state stops it.
   assign sclk_run = (state_reg != PLC_DISABLED); // RULE6

   // ------------------------------------------------------------
   // Link-on indication
   // ------------------------------------------------------------
   logic lon_set;
   logic lon_keep_on_reset;
   logic lon_clear;

   always_comb begin
      lon_set = link_on_event && (!lps_lvl || !link_control_enable_bit); // RULE12
      lon_keep_on_reset = port_event_bit || (watchdog_bit && fault_condition);
      lon_clear = (bus_reset && !lon_keep_on_reset) ||
                  (state_reg == PLC_ACTIVE && link_control_enable_bit); // RULE13
      lon_active_next = lon_active_reg;
      if (lon_set) begin
         lon_active_next = 1'b1;
      end else if (lon_clear) begin
         lon_active_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lon_active_reg <= 1'b0;
      end else begin
         lon_active_reg <= lon_active_next;
      end
   end

   // ------------------------------------------------------------
   // Control and data line drive
   // ------------------------------------------------------------
   logic [1:0] ctl_next, ctl_reg;
   logic [7:0] d_next, d_reg;
   logic bus_oe_next, bus_oe_reg;
   logic sclk_o_next, sclk_o_reg, sclk_oe_next, sclk_oe_reg;
   logic lon_o_next, lon_o_reg;
   logic in_zero_window;
   logic at_prefix;

   always_comb begin
      ctl_next = CTL_IDLE;
      d_next = DATA_ZERO;
      bus_oe_next = 1'b1;
      sclk_o_next = sclk_wave;
      sclk_oe_next = 1'b1;
      in_zero_window = (start_cnt_reg != 4'h0) && (start_cnt_reg <= STARTUP_ZERO_LAST);
      at_prefix = (start_cnt_reg == STARTUP_PREFIX);
      lon_o_next = lon_active_reg && lon_wave; // RULE11 RULE14
      case (state_reg)
         PLC_RESET: begin
            bus_oe_next = dc_coupling; // RULE1
         end
         PLC_DISABLED: begin
            bus_oe_next = dc_coupling;
            sclk_o_next = 1'b0; // RULE2
            sclk_oe_next = dc_coupling;
         end
         PLC_STARTUP: begin
            if (at_prefix) begin
               ctl_next = CTL_RECEIVE; // RULE7 RULE8
               d_next = DATA_PREFIX;
            end else if (dc_coupling) begin
               bus_oe_next = in_zero_window; // RULE7
            end else begin
               bus_oe_next = (start_cnt_reg == STARTUP_AC_ZERO); // RULE8
            end
         end
         PLC_ACTIVE: begin
            // The link's own requests travel on a separate pin.
            if (rx_active) begin
               ctl_next = CTL_RECEIVE; // RULE17 RULE9
               d_next = rx_data;
            end else if (grant_req) begin
               ctl_next = CTL_GRANT; // RULE18
            end else if (status_req && !drop_reg) begin
               ctl_next = CTL_STATUS; // RULE5 RULE15
               d_next = status_data;
            end
            // After a grant, the link holds the lines while it drives
            // idle, hold or transmit codes.
            if (link_tx_active && !rx_active) begin
               bus_oe_next = 1'b0; // RULE16
            end
         end
         default: begin
            bus_oe_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctl_reg <= CTL_IDLE;
         d_reg <= DATA_ZERO;
         bus_oe_reg <= 1'b0;
         sclk_o_reg <= 1'b0;
         sclk_oe_reg <= 1'b0;
         lon_o_reg <= 1'b0;
      end else begin
         ctl_reg <= ctl_next;
         d_reg <= d_next;
         bus_oe_reg <= bus_oe_next;
         sclk_o_reg <= sclk_o_next;
         sclk_oe_reg <= sclk_oe_next;
         lon_o_reg <= lon_o_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   logic [1:0] state_out_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_out_reg <= PLC_DISABLED;
      end else begin
         state_out_reg <= state_next;
      end
   end

   assign sclk_o = sclk_o_reg;
   assign sclk_oe = sclk_oe_reg;
   assign ctl_o = ctl_reg;
   assign ctl_oe = bus_oe_reg;
   assign d_o = d_reg;
   assign d_oe = bus_oe_reg;
   assign link_on_o = lon_o_reg;
   assign req_cancel = cancel_reg;
   assign tx_forced_end = tx_end_reg;
   assign status_drop = drop_reg;
   assign if_state = plc_state_e'(state_out_reg);

endmodule
`default_nettype wire

/* plc_link_ctl_props.sv */
`timescale 1ns/10ps
`default_nettype none
module plc_link_ctl_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Inputs watched
   input wire logic dc_coupling,
   input wire logic rx_active,
   input wire logic [7:0] rx_data,
   input wire logic bus_reset,
   // Outputs watched
   input wire logic sclk_o,
   input wire logic sclk_oe,
   input wire logic [1:0] ctl_o,
   input wire logic ctl_oe,
   input wire logic [7:0] d_o,
   input wire logic d_oe,
   input wire logic link_on_o,
   input wire logic req_cancel,
   input wire logic status_drop,
   input wire plc_pkg::plc_state_e if_state
);
   import plc_pkg::*;
   // ------------------------------------------------------------
   // High-phase length of the link-on wave
   // ------------------------------------------------------------
   logic [4:0] hi_reg;
   logic [4:0] hi_next;
   always_comb begin
      hi_next = link_on_o ? hi_reg + 5'h1 : 5'h0;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hi_reg <= 5'h0;
      end else begin
         hi_reg <= hi_next;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   chk_dc_reset: assert property (
      (if_state == PLC_RESET && $past(if_state) == PLC_RESET && dc_coupling && $stable(dc_coupling))
      |-> (ctl_oe && d_oe && ctl_o == CTL_IDLE && d_o == DATA_ZERO))
      else $error("reset interface not driven low");
   chk_dc_disable: assert property (
      (if_state == PLC_DISABLED && $past(if_state) == PLC_DISABLED && !$past(rst) && dc_coupling
      && $stable(dc_coupling)) |-> (sclk_oe && !sclk_o && ctl_oe && ctl_o == CTL_IDLE
      && d_o == DATA_ZERO))
      else $error("disabled interface not driven low");
   chk_ac_float: assert property (
      ((if_state == PLC_RESET || if_state == PLC_DISABLED) && $stable(if_state) && !$past(rst)
      && !dc_coupling && $stable(dc_coupling)) |-> (!ctl_oe && !d_oe))
      else $error("interface lines not floated");
   chk_no_status: assert property (
      (status_drop && $past(status_drop)) |-> !(ctl_oe && ctl_o == CTL_STATUS))
      else $error("status shown while dropped");
   chk_cancel_reset: assert property (
      (if_state == PLC_RESET && $past(if_state) != PLC_RESET)
      |-> ((req_cancel || $past(req_cancel)) or (##1 req_cancel)))
      else $error("no cancel on interface reset");
   chk_rx_first: assert property (
      (if_state == PLC_ACTIVE && $past(if_state) == PLC_ACTIVE && $past(rx_active))
      |-> (ctl_oe && ctl_o == CTL_RECEIVE && d_o == $past(rx_data)))
      else $error("reception not given priority");
   chk_sclk_start: assert property (
      $rose(if_state == PLC_STARTUP) |-> ##[1:6] (sclk_oe && $rose(sclk_o)))
      else $error("interface clock not started");
   chk_linkon_high: assert property (
      hi_reg <= 5'hb)
      else $error("link-on high phase too long");
   chk_linkon_half: assert property (
      ($fell(link_on_o) && !$past(bus_reset) && !$past(bus_reset, 2) && if_state != PLC_ACTIVE
      && $past(if_state) != PLC_ACTIVE) |-> (hi_reg >= 5'h9))
      else $error("link-on high phase too short");
endmodule
bind plc_link_ctl plc_link_ctl_props i_props (.clk_sys, .rst, .dc_coupling, .rx_active,
   .rx_data, .bus_reset, .sclk_o, .sclk_oe, .ctl_o, .ctl_oe, .d_o, .d_oe, .link_on_o,
   .req_cancel, .status_drop, .if_state);
`default_nettype wire

/* plc_lps_model.sv */
`timescale 1ns/10ps
`default_nettype none
module plc_lps_model (
   // Link clock and requested state: 0 off, 1 on, 2 pulsed
   input wire logic clk_link,
   input wire logic [1:0] lps_mode,
   // Power state pin
   output logic lps_pin
);
   logic [1:0] ph_reg;
   initial begin
      ph_reg = 2'h0;
      lps_pin = 1'b0;
   end
   always @(posedge clk_link) begin
      ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
      if (lps_mode == 2'h2) begin
         // Three link clocks a phase, 480 ns, well inside the allowed width.
         if (ph_reg == 2'h2) begin
            lps_pin <= !lps_pin;
         end
      end else begin
         lps_pin <= lps_mode[0];
      end
   end
endmodule
`default_nettype wire

/* tb_phy_link_power_and_ctl_control.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_phy_link_power_and_ctl_control;
   import plc_pkg::*;
   logic clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, lps_pin, lo_prev = 1'b0;
   logic [1:0] lps_mode = 2'h0;
   logic dc_coupling = 1'b1, rx_active = 1'b0, status_req = 1'b0, grant_req = 1'b0;
   logic link_tx_active = 1'b0, link_on_event = 1'b0, bus_reset = 1'b0, port_event_bit = 1'b0;
   logic watchdog_bit = 1'b0, fault_condition = 1'b0, link_control_enable_bit = 1'b0;
   logic [7:0] rx_data = 8'h5a, status_data = 8'ha5, d_o;
   logic sclk_o, sclk_oe, ctl_oe, d_oe, link_on_o, req_cancel, tx_forced_end, status_drop;
   logic [1:0] ctl_o;
   plc_state_e if_state;
   int n_mismatch = 0, checked = 0, n_cancel = 0, n_fend = 0, n_status = 0, n_rise = 0;
   always #4 clk_sys = ~clk_sys;
   always #80 clk_link = ~clk_link;
   plc_lps_model i_link (.clk_link, .lps_mode, .lps_pin);
   plc_link_ctl i_dut (.clk_sys, .rst, .lps_pin, .dc_coupling, .rx_active, .rx_data,
      .status_req, .status_data, .grant_req, .link_tx_active, .link_on_event, .bus_reset,
      .port_event_bit, .watchdog_bit, .fault_condition, .link_control_enable_bit, .sclk_o,
      .sclk_oe, .ctl_o, .ctl_oe, .d_o, .d_oe, .link_on_o, .req_cancel, .tx_forced_end,
      .status_drop, .if_state);
   always @(negedge clk_sys) begin
      n_cancel += int'(req_cancel === 1'b1);
      n_fend += int'(tx_forced_end === 1'b1);
      n_status += int'(ctl_oe === 1'b1 && ctl_o === CTL_STATUS);
      n_rise += int'(link_on_o === 1'b1 && lo_prev === 1'b0);
      lo_prev = link_on_o;
   end
   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic in_range(input string what, input int lo, input int hi, input int got);
      checked++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("mismatch %s expected %0d to %0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic wait_state(input plc_state_e s, input int lim, output int n);
      n = 0;
      while (if_state !== s && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_startup(input logic dcv);
      int n, rises, drv;
      logic pre, ps;
      @(posedge clk_sys);
      dc_coupling <= dcv;
      lps_mode <= 2'h1;
      rx_active <= !dcv;
      wait_state(PLC_STARTUP, 400, n);
      rises = 0;
      drv = 0;
      pre = 1'b0;
      ps = sclk_o;
      for (int i = 0; i < 60 && !pre; i++) begin
         @(negedge clk_sys);
         rises += int'(sclk_o === 1'b1 && ps === 1'b0);
         ps = sclk_o;
         pre = ctl_oe === 1'b1 && ctl_o === CTL_RECEIVE && d_o === DATA_PREFIX;
         if (ctl_oe !== 1'b0 && !pre) begin
            drv++;
            check("startup_zero", 16'h0, 16'({ctl_o, d_o}));
         end
      end
      in_range("prefix_clocks", 8, 8, rises);
      in_range("zero_clocks", dcv ? 7 : 1, dcv ? 7 : 1, (drv + 2) / 4);
      repeat (12) @(negedge clk_sys);
      check("rx_prefix", dcv ? 16'h0400 : 16'h06ff, 16'({ctl_oe, ctl_o, d_o}));
      @(posedge clk_sys);
      rx_active <= 1'b0;
      wait_state(PLC_ACTIVE, 20, n);
      check("state_active", 16'(PLC_ACTIVE), 16'(if_state));
   endtask
   task automatic t_codes;
      logic [1:0] e;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_sys);
         rx_active <= k[2];
         grant_req <= k[1];
         status_req <= k[0];
         @(posedge clk_sys);
         @(negedge clk_sys);
         e = k[2] ? CTL_RECEIVE : k[1] ? CTL_GRANT : k[0] ? CTL_STATUS : CTL_IDLE;
         check("ctl_code", 16'({1'b1, e}), 16'({ctl_oe, ctl_o}));
         if (k[2] || k == 1) begin
            check("ctl_data", 16'(k[2] ? rx_data : status_data), 16'(d_o));
         end
      end
      @(posedge clk_sys);
      {rx_active, grant_req, status_req} <= 3'h0;
   endtask
   task automatic t_pulse;
      int bad;
      bad = 0;
      @(posedge clk_sys);
      lps_mode <= 2'h2;
      repeat (1250) begin
         @(negedge clk_sys);
         bad += int'(if_state !== PLC_ACTIVE);
      end
      in_range("pulsed_lps_kept", 0, 0, bad);
      @(posedge clk_sys);
      lps_mode <= 2'h1;
      repeat (40) @(negedge clk_sys);
   endtask
   task automatic t_power_down(input logic dcv);
      int n, m, c0, f0, s0;
      c0 = n_cancel;
      f0 = n_fend;
      @(posedge clk_sys);
      lps_mode <= 2'h0;
      link_tx_active <= 1'b1;
      repeat (2) @(negedge clk_sys);
      check("link_owns_bus", 16'h0, 16'({ctl_oe, d_oe}));
      wait_state(PLC_RESET, 400, n);
      in_range("reset_time", 150, 338, n + 2);
      repeat (4) @(negedge clk_sys);
      in_range("cancel_count", c0 + 1, c0 + 1, n_cancel);
      in_range("tx_end_count", f0 + 1, f0 + 1, n_fend);
      check("reset_drive", 16'({dcv, 10'h0}), 16'({ctl_oe, dcv ? {ctl_o, d_o} : 10'h0}));
      @(posedge clk_sys);
      link_tx_active <= 1'b0;
      status_req <= 1'b1;
      s0 = n_status;
      wait_state(PLC_DISABLED, 4000, m);
      in_range("disable_time", 3125, 3750, n + m + 6);
      repeat (4) @(negedge clk_sys);
      check("disable_drive", 16'({dcv, dcv, 1'b1}), 16'({sclk_oe, ctl_oe, status_drop}));
      check("disable_sclk", 16'h0, 16'(dcv ? sclk_o : 1'b0));
      in_range("status_blocked", s0, s0, n_status);
      @(posedge clk_sys);
      status_req <= 1'b0;
   endtask
   task automatic t_linkon;
      int r0;
      check("linkon_idle", 16'h0, 16'(link_on_o));
      @(posedge clk_sys);
      link_on_event <= 1'b1;
      @(posedge clk_sys);
      link_on_event <= 1'b0;
      r0 = n_rise;
      repeat (1000) @(negedge clk_sys);
      in_range("linkon_rises", 48, 51, n_rise - r0);
      @(posedge clk_sys);
      bus_reset <= 1'b1;
      @(posedge clk_sys);
      bus_reset <= 1'b0;
      repeat (4) @(negedge clk_sys);
      r0 = n_rise;
      repeat (100) @(negedge clk_sys);
      in_range("linkon_cleared", 0, 0, n_rise - r0);
      @(posedge clk_sys);
      port_event_bit <= 1'b1;
      link_on_event <= 1'b1;
      @(posedge clk_sys);
      link_on_event <= 1'b0;
      bus_reset <= 1'b1;
      @(posedge clk_sys);
      bus_reset <= 1'b0;
      r0 = n_rise;
      repeat (100) @(negedge clk_sys);
      in_range("linkon_kept", 4, 6, n_rise - r0);
      @(posedge clk_sys);
      port_event_bit <= 1'b0;
      bus_reset <= 1'b1;
      @(posedge clk_sys);
      bus_reset <= 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      t_startup(1'b1);
      t_codes();
      t_pulse();
      t_power_down(1'b1);
      t_linkon();
      t_startup(1'b0);
      t_power_down(1'b0);
      conclude();
   end
   // The run needs about 9000 cycles; the limit leaves ample slack.
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_mismatch++;
      conclude();
   end
endmodule
`default_nettype wire
